// ---- inc/clkmon_map.svh ----
// Purpose: Register map, field positions, reset values and timing counts.
// Assumes: 32-bit AXI4-Lite words, one register per aligned word.
// Notes: Offsets are the word index times four.
`ifndef CLKMON_MAP_SVH
`define CLKMON_MAP_SVH
`define ADDR_W 8
`define IDX_ENABLE 0
`define IDX_INCFG 1
`define IDX_MONCFG 2
`define IDX_GPIOCFG 3
`define IDX_ACTCFG 4
`define IDX_PCTCFG 5
`define IDX_NOM1 6
`define IDX_TIMECFG 9
`define IDX_PRIO_A 10
`define IDX_PRIO_B 11
`define IDX_VALCTRL 12
`define IDX_SELCTRL 13
`define IDX_STATUS 14
`define IDX_VALID_STATUS_REGS 15
`define CFG_WORDS 14
`define RST_ENABLE 32'h0000_0007
`define RST_ACTCFG 32'h0140_03E8
`define RST_PCTCFG 32'h0000_000A
`define RST_NOM 32'h0000_00C8
`define RST_PRIO_A 32'h0000_0021
`define RST_PRIO_B 32'h0000_0003
`define RST_VALCTRL 32'h0000_0007
`define POL_BIT 0
`define HSDIV_LSB 1
`define ACTEN_BIT 0
`define PCTEN_BIT 1
`define LOSSRC_LSB 2
`define CHG_LSB 8
`define LOCK_TIMEOUT_FLAG_LSB 16
`define GPIO_CFG_INV 4'h1
`define GPIO_CFG_PLAIN 4'h2
`define LOS_SRC_GPIO1 3'h2
`define PCT_MIN 5'h01
`define PCT_MAX 5'h14
`define PCT_SCALE 8'h64
`define CLK_PERIOD_NS 50
`define TICK_NS 1000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- inc/clkmon_pkg.sv ----
// Purpose: Types shared by the input clock monitor.
// Assumes: Map header supplies all numbers.
// Notes: All state of the block is one packed struct.
`include "clkmon_map.svh"
package clkmon_pkg;
    typedef logic [2:0][15:0] cnt3_t;
    typedef struct packed {
        logic [`CFG_WORDS-1:0][31:0] cfg;
        logic [2:0] prev_in;
        logic [2:0][2:0] div_cnt;
        logic [2:0] div_edge;
        logic [15:0] win_cnt;
        cnt3_t edge_cnt;
        logic [2:0] act_ok;
        logic [2:0] pct_ok;
        logic [2:0] pct_armed;
        cnt3_t val_cnt;
        logic [2:0] valid_prev;
        logic [2:0] chg;
        logic [2:0] lock_timeout_flag;
        logic [15:0] tick_cnt;
        logic tick;
        logic [15:0] lk_cnt;
        logic [1:0] sel;
        logic sel_valid;
        logic gp_out;
        logic gp_oe;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [`ADDR_W-1:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mon_state_t;
endpackage

// ---- verilog/input_clock_monitor_priority.sv ----
// Purpose: Three-input clock monitor, validation and reference selection.
// Assumes: Clock pins and GPIOs are synchronous samples of REF_CLK.
// Notes: Monitors and dividers run only from REF_CLK, the master clock.
`timescale 1ns/10ps
module input_clock_monitor_priority
    import clkmon_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
)
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [2:0] IN_CLK,
    input wire logic [1:0] GPIO_PIN_IN,
    input wire logic EXT_SEL,
    input wire logic DPLL_LOCKED,
    output logic THIRD_PIN_OUT,
    output logic THIRD_PIN_OE,
    output logic [2:0] DIV_EDGE,
    output logic [1:0] SEL_REF,
    output logic SEL_VALID,
    input wire logic [`ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [`ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    mon_state_t s_reg;
    mon_state_t s_next;
    logic [2:0] los;
    logic [2:0] val;
    logic [2:0] validated_timer_bit;
    logic [2:0] valid_rt;
    logic [2:0] elig;
    logic [2:0][3:0] prio;
    logic [2:0] gpio_lvl;
    logic ext_sw;

    assign ext_sw = s_reg.cfg[`IDX_SELCTRL][0];
    assign prio[0] = s_reg.cfg[`IDX_PRIO_A][3:0];
    assign prio[1] = s_reg.cfg[`IDX_PRIO_A][7:4];
    assign prio[2] = s_reg.cfg[`IDX_PRIO_B][3:0];

    always_comb
    begin
        logic [3:0] gcode;
        logic [2:0] src;
        logic [31:0] word;
        logic [15:0] diff;
        logic [23:0] lhs;
        logic [23:0] rhs;
        logic [4:0] thr;
        logic [3:0] bestp;
        logic [1:0] best;
        logic any;
        logic cur_ok;
        logic win_end;
        logic edge_seen;
        logic [3:0] ridx;
        gcode = '0;
        src = '0;
        word = '0;
        diff = '0;
        lhs = '0;
        rhs = '0;
        thr = '0;
        bestp = 4'hF;
        best = 2'h0;
        any = 1'b0;
        cur_ok = 1'b0;
        edge_seen = 1'b0;
        ridx = '0;
        s_next = s_reg;
        los = '0;
        val = '0;
        validated_timer_bit = '0;
        valid_rt = '0;
        elig = '0;
        gpio_lvl = '0;
        for (int g = 0; g < 3; g++)
        begin
            gcode = s_reg.cfg[`IDX_GPIOCFG][4*g +: 4];
            if (g < 2)
                edge_seen = GPIO_PIN_IN[g];
            else
                edge_seen = IN_CLK[2] & ~s_reg.cfg[`IDX_ENABLE][2];
            if (gcode == `GPIO_CFG_INV)
                gpio_lvl[g] = ~edge_seen;
            else if (gcode == `GPIO_CFG_PLAIN)
                gpio_lvl[g] = edge_seen;
        end
        gcode = s_reg.cfg[`IDX_GPIOCFG][11:8];
        s_next.gp_oe = ~s_reg.cfg[`IDX_ENABLE][2] & gcode[2];
        s_next.gp_out = gcode[0];
        // The tick paces validation and lock timers at a coarse rate.
        s_next.tick = 1'b0;
        s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
        if (s_reg.tick_cnt >= 16'(TICK_CYCLES - 1))
        begin
            s_next.tick_cnt = '0;
            s_next.tick = 1'b1;
        end
        win_end = s_reg.win_cnt + 16'h0001 >= s_reg.cfg[`IDX_ACTCFG][15:0];
        s_next.win_cnt = win_end ? 16'h0000 : s_reg.win_cnt + 16'h0001;
        thr = s_reg.cfg[`IDX_PCTCFG][4:0];
        // Threshold clamped to one to twenty
        if (thr < `PCT_MIN)
            thr = `PCT_MIN;
        else if (thr > `PCT_MAX)
            thr = `PCT_MAX;
        // All monitor logic clocked by master clock
        for (int i = 0; i < 3; i++)
        begin
            s_next.prev_in[i] = IN_CLK[i];
            if (s_reg.cfg[`IDX_INCFG][8*i + `POL_BIT])
                edge_seen = s_reg.prev_in[i] & ~IN_CLK[i];
            else
                edge_seen = ~s_reg.prev_in[i] & IN_CLK[i];
            edge_seen = edge_seen & s_reg.cfg[`IDX_ENABLE][i];
            s_next.div_edge[i] = 1'b0;
            if (edge_seen)
            begin
                s_next.div_cnt[i] = s_reg.div_cnt[i] + 3'h1;
                if (s_reg.div_cnt[i] == 3'((4'h1 <<
                    s_reg.cfg[`IDX_INCFG][8*i + `HSDIV_LSB +: 2]) - 4'h1))
                begin
                    s_next.div_cnt[i] = '0;
                    s_next.div_edge[i] = 1'b1;
                end
            end
            if (win_end)
                s_next.edge_cnt[i] = '0;
            else if (s_reg.div_edge[i] && s_reg.edge_cnt[i] != 16'hFFFF)
                s_next.edge_cnt[i] = s_reg.edge_cnt[i] + 16'h0001;
            src = s_reg.cfg[`IDX_MONCFG][8*i + `LOSSRC_LSB +: 3];
            if (src >= `LOS_SRC_GPIO1 && src <= `LOS_SRC_GPIO1 + 3'h2)
                los[i] = gpio_lvl[2'(src - `LOS_SRC_GPIO1)];
            if (los[i])
                s_next.act_ok[i] = 1'b0;
            else if (!s_reg.cfg[`IDX_MONCFG][8*i + `ACTEN_BIT])
                s_next.act_ok[i] = 1'b1;
            else if (win_end)
                s_next.act_ok[i] =
                    s_reg.edge_cnt[i] >= 16'(s_reg.cfg[`IDX_ACTCFG][31:24])
                    && s_reg.edge_cnt[i] <=
                    16'(s_reg.cfg[`IDX_ACTCFG][23:16]);
            diff = s_reg.edge_cnt[i] > s_reg.cfg[`IDX_NOM1 + i][15:0] ?
                s_reg.edge_cnt[i] - s_reg.cfg[`IDX_NOM1 + i][15:0] :
                s_reg.cfg[`IDX_NOM1 + i][15:0] - s_reg.edge_cnt[i];
            lhs = 24'(diff) * 24'(`PCT_SCALE);
            rhs = 24'(s_reg.cfg[`IDX_NOM1 + i][15:0]) * 24'(thr);
            if (!s_next.act_ok[i])
            begin
                s_next.pct_ok[i] = 1'b0;
                s_next.pct_armed[i] = 1'b0;
            end
            else if (!s_reg.cfg[`IDX_MONCFG][8*i + `PCTEN_BIT])
                s_next.pct_ok[i] = 1'b1;
            // Only a window that began with activity valid is judged.
            else if (win_end)
            begin
                s_next.pct_ok[i] = s_reg.pct_armed[i] && lhs <= rhs;
                s_next.pct_armed[i] = 1'b1;
            end
            val[i] = s_reg.act_ok[i] & s_reg.pct_ok[i] & ~los[i];
            if (!val[i])
                s_next.val_cnt[i] = '0;
            else if (s_reg.tick &&
                s_reg.val_cnt[i] < s_reg.cfg[`IDX_TIMECFG][15:0])
                s_next.val_cnt[i] = s_reg.val_cnt[i] + 16'h0001;
            validated_timer_bit[i] = val[i] &&
                s_reg.val_cnt[i] >= s_reg.cfg[`IDX_TIMECFG][15:0];
            valid_rt[i] = validated_timer_bit[i] & ~s_reg.lock_timeout_flag[i] &
                s_reg.cfg[`IDX_ENABLE][i];
            elig[i] = valid_rt[i] & s_reg.cfg[`IDX_VALCTRL][i] &
                (prio[i] != 4'h0);
        end
        // Lowest nonzero value wins, low index on ties
        for (int i = 2; i >= 0; i--)
        begin
            if (elig[i] && prio[i] <= bestp)
            begin
                bestp = prio[i];
                best = 2'(i);
                any = 1'b1;
            end
        end
        cur_ok = s_reg.sel_valid && s_reg.sel != 2'h3 && elig[s_reg.sel];
        if (ext_sw)
        begin
            s_next.sel = EXT_SEL ? (prio[0] != 4'h0 ? 2'h0 : 2'h2) : 2'h1;
            s_next.sel_valid = 1'b1;
        end
        // Automatic choice of best valid input
        else if (!cur_ok)
        begin
            s_next.sel = best;
            s_next.sel_valid = any;
        end
        else if (s_reg.cfg[`IDX_SELCTRL][1] && bestp < prio[s_reg.sel])
            s_next.sel = best;
        if (ext_sw || !s_reg.sel_valid || DPLL_LOCKED ||
            s_next.sel != s_reg.sel)
            s_next.lk_cnt = '0;
        else if (s_reg.tick)
            s_next.lk_cnt = s_reg.lk_cnt + 16'h0001;
        // AXI4-Lite slave; writes wait until address and data are both in.
        if (AWVALID && s_reg.awready)
        begin
            s_next.aw_have = 1'b1;
            s_next.aw_addr = AWADDR;
        end
        if (WVALID && s_reg.wready)
        begin
            s_next.w_have = 1'b1;
            s_next.wdata = WDATA;
            s_next.wstrb = WSTRB;
        end
        if (s_reg.bvalid && BREADY)
            s_next.bvalid = 1'b0;
        if (s_reg.aw_have && s_reg.w_have)
        begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `RESP_OKAY;
            ridx = s_reg.aw_addr[5:2];
            if (s_reg.aw_addr[`ADDR_W-1:6] != '0 || ridx == `IDX_STATUS)
                s_next.bresp = `RESP_SLVERR;
            else if (ridx == `IDX_VALID_STATUS_REGS)
            begin
                if (s_reg.wstrb[1])
                    s_next.chg = s_reg.chg & ~s_reg.wdata[`CHG_LSB +: 3];
                if (s_reg.wstrb[2])
                    s_next.lock_timeout_flag = s_reg.lock_timeout_flag & ~s_reg.wdata[`LOCK_TIMEOUT_FLAG_LSB +: 3];
            end
            else
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (s_reg.wstrb[b])
                        s_next.cfg[ridx][8*b +: 8] = s_reg.wdata[8*b +: 8];
                end
            end
        end
        // Hardware sets come after the clears so that a set wins.
        for (int i = 0; i < 3; i++)
        begin
            s_next.valid_prev[i] = valid_rt[i];
            if (valid_rt[i] != s_reg.valid_prev[i])
                s_next.chg[i] = 1'b1;
        end
        if (s_reg.cfg[`IDX_TIMECFG][31:16] != 16'h0000 &&
            s_reg.lk_cnt >= s_reg.cfg[`IDX_TIMECFG][31:16] &&
            s_reg.sel != 2'h3)
        begin
            s_next.lock_timeout_flag[s_reg.sel] = 1'b1;
            s_next.lk_cnt = '0;
        end
        if (s_reg.rvalid && RREADY)
            s_next.rvalid = 1'b0;
        if (ARVALID && s_reg.arready)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp = `RESP_OKAY;
            ridx = ARADDR[5:2];
            word = '0;
            if (ARADDR[`ADDR_W-1:6] != '0)
                s_next.rresp = `RESP_SLVERR;
            else if (ridx == `IDX_STATUS)
            begin
                for (int i = 0; i < 3; i++)
                    word[8*i +: 8] = {2'h0, s_reg.lock_timeout_flag[i], validated_timer_bit[i], val[i],
                        los[i], s_reg.pct_ok[i], s_reg.act_ok[i]};
            end
            else if (ridx == `IDX_VALID_STATUS_REGS)
                word = {6'h00, s_reg.sel, 5'h00, s_reg.lock_timeout_flag, 5'h00,
                    s_reg.chg, 5'h00, valid_rt};
            else
                word = s_reg.cfg[ridx];
            s_next.rdata = word;
        end
        s_next.awready = ~s_next.aw_have & ~s_next.bvalid;
        s_next.wready = ~s_next.w_have & ~s_next.bvalid;
        s_next.arready = ~s_next.rvalid;
        if (RST)
        begin
            s_next = '0;
            s_next.cfg[`IDX_ENABLE] = `RST_ENABLE;
            s_next.cfg[`IDX_ACTCFG] = `RST_ACTCFG;
            s_next.cfg[`IDX_PCTCFG] = `RST_PCTCFG;
            for (int i = 0; i < 3; i++)
                s_next.cfg[`IDX_NOM1 + i] = `RST_NOM;
            s_next.cfg[`IDX_PRIO_A] = `RST_PRIO_A;
            s_next.cfg[`IDX_PRIO_B] = `RST_PRIO_B;
            s_next.cfg[`IDX_VALCTRL] = `RST_VALCTRL;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        s_reg <= s_next;
    end

    assign THIRD_PIN_OUT = s_reg.gp_out;
    assign THIRD_PIN_OE = s_reg.gp_oe;
    assign DIV_EDGE = s_reg.div_edge;
    assign SEL_REF = s_reg.sel;
    assign SEL_VALID = s_reg.sel_valid;
    assign AWREADY = s_reg.awready;
    assign WREADY = s_reg.wready;
    assign BVALID = s_reg.bvalid;
    assign BRESP = s_reg.bresp;
    assign ARREADY = s_reg.arready;
    assign RVALID = s_reg.rvalid;
    assign RDATA = s_reg.rdata;
    assign RRESP = s_reg.rresp;

    default clocking dflt_cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    a_rcv_off_invalid: assert property (
        !s_reg.cfg[`IDX_ENABLE][0] |-> !valid_rt[0])
        else $error("Disabled receiver reads valid.");
    a_los_kills_monitors: assert property (
        los[1] |=> !s_reg.act_ok[1] && !s_reg.pct_ok[1])
        else $error("Loss of signal did not force monitors invalid.");
    a_pct_under_act: assert property (
        !s_reg.act_ok[2] |-> !s_reg.pct_ok[2])
        else $error("Percent valid while activity invalid.");
    a_act_off_valid: assert property (
        !s_reg.cfg[`IDX_MONCFG][`ACTEN_BIT] && !los[0] |=> s_reg.act_ok[0])
        else $error("Disabled activity monitor not valid.");
    a_change_latched: assert property (
        valid_rt[0] != s_reg.valid_prev[0] |=> s_reg.chg[0])
        else $error("Validity change not latched.");
    a_validated_timer_bit_after_val: assert property (
        validated_timer_bit[1] |-> val[1] && s_reg.val_cnt[1] >=
        s_reg.cfg[`IDX_TIMECFG][15:0])
        else $error("Validated before timer expired.");
    a_lock_timeout_flag_invalid: assert property (
        s_reg.lock_timeout_flag[2] |-> !valid_rt[2])
        else $error("Timed-out input still valid.");
    a_mask_excluded: assert property (
        !ext_sw && !s_reg.cfg[`IDX_VALCTRL][0] |=>
        !(s_reg.sel_valid && s_reg.sel == 2'h0) || $past(ext_sw))
        else $error("Masked input selected automatically.");
    a_prio_zero_excluded: assert property (
        !ext_sw && prio[1] == 4'h0 |=>
        !(s_reg.sel_valid && s_reg.sel == 2'h1) || $past(ext_sw))
        else $error("Priority zero input selected.");
    a_reset_priorities: assert property (
        $fell(RST) |-> prio[0] == 4'h1 && prio[1] == 4'h2 &&
        prio[2] == 4'h3 && !s_reg.cfg[`IDX_INCFG][`POL_BIT])
        else $error("Wrong priorities after reset.");
    a_revertive_switch_bit_switch: assert property (
        !ext_sw && cur_sel_ok() && s_reg.cfg[`IDX_SELCTRL][1] &&
        elig[0] && prio[0] < prio[s_reg.sel] &&
        (!elig[1] || prio[0] <= prio[1]) &&
        (!elig[2] || prio[0] <= prio[2]) |=> s_reg.sel == 2'h0)
        else $error("Revertive switch missed.");

    function automatic logic cur_sel_ok();
        return s_reg.sel_valid && s_reg.sel != 2'h3 && elig[s_reg.sel];
    endfunction

    c_change_seen: cover property (s_reg.chg[0] && valid_rt[0]);
    c_lock_timeout: cover property ($rose(s_reg.lock_timeout_flag[0]));
    c_ref_switch: cover property (s_reg.sel_valid &&
        $changed(s_reg.sel));
endmodule // input_clock_monitor_priority

// ---- verification/ref_source.sv ----
// Purpose: Reference clock sources feeding the three monitored inputs.
// Assumes: Each source toggles at REF_CLK edges, half period in cycles.
// Notes: A half period of zero stops the source where it stands.
`timescale 1ns/10ps
module ref_source
(
    input wire logic clk,
    input wire logic [2:0][3:0] half,
    output logic [2:0] clk_out
);
    logic [2:0][3:0] cnt = '0;
    logic [2:0] lvl = 3'h0;
    assign clk_out = lvl;
    // Rate kept low.
    // The fastest toggle is one REF_CLK cycle, so the sampled input
    // never aliases, though the divided rate can exceed the activity maximum.
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (half[i] == 4'h0)
                cnt[i] <= 4'h0;
            else if (cnt[i] + 4'h1 >= half[i])
            begin
                cnt[i] <= 4'h0;
                lvl[i] <= ~lvl[i];
            end
            else
                cnt[i] <= cnt[i] + 4'h1;
        end
    end
endmodule // ref_source

// ---- verification/tb.sv ----
// Purpose: Register-level test of the input clock monitor.
// Assumes: AXI4-Lite master tasks, TICK_CYCLES shortened to 4.
// Notes: Windows of 100 cycles see 25 edges at the nominal rate.
`timescale 1ns/10ps
module tb;
    import clkmon_pkg::*;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [2:0] IN_CLK;
    logic [1:0] GPIO_PIN_IN = 2'h3;
    logic EXT_SEL = 1'b0;
    logic DPLL_LOCKED = 1'b1;
    logic THIRD_PIN_OUT, THIRD_PIN_OE, SEL_VALID;
    logic [2:0] DIV_EDGE;
    logic [1:0] SEL_REF, BRESP, RRESP;
    logic [`ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
    logic [31:0] WDATA = '0, RDATA;
    logic [3:0] WSTRB = 4'hF;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    // Equal rates share one detector rate.
    logic [2:0][3:0] half = {4'h2, 4'h2, 4'h2};
    int fails = 0;
    int n_compared = 0;
    int k, n;
    always #25 REF_CLK = ~REF_CLK;
    ref_source u_src (.clk(REF_CLK), .half(half), .clk_out(IN_CLK));
    input_clock_monitor_priority #(.TICK_CYCLES(4)) u_dut (
        .REF_CLK(REF_CLK), .RST(RST), .IN_CLK(IN_CLK),
        .GPIO_PIN_IN(GPIO_PIN_IN), .EXT_SEL(EXT_SEL),
        .DPLL_LOCKED(DPLL_LOCKED), .THIRD_PIN_OUT(THIRD_PIN_OUT),
        .THIRD_PIN_OE(THIRD_PIN_OE), .DIV_EDGE(DIV_EDGE),
        .SEL_REF(SEL_REF), .SEL_VALID(SEL_VALID), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
    task finish_test();
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready and answer are looked at before the edge that takes them.
    task axw(input logic [7:0] a, input logic [31:0] d,
             input logic [1:0] er);
        int i;
        logic ta, tw, tk;
        logic [1:0] r;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(negedge REF_CLK);
            ta = AWVALID && AWREADY;
            tw = WVALID && WREADY;
            tk = BVALID;
            r = BRESP;
            @(posedge REF_CLK);
            if (ta) AWVALID <= 1'b0;
            if (tw) WVALID <= 1'b0;
            if (tk) break;
        end
        BREADY <= 1'b0;
        @(posedge REF_CLK);
        chk(32'(i < 50), 32'h1);
        chk(32'(r), 32'(er));
        if (i == 50) finish_test();
    endtask
    task axr(input logic [7:0] a, output logic [31:0] d,
             output logic [1:0] r);
        int i;
        logic tk;
        logic ta;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(negedge REF_CLK);
            tk = RVALID;
            d = RDATA;
            r = RRESP;
            ta = ARVALID && ARREADY;
            @(posedge REF_CLK);
            if (ta) ARVALID <= 1'b0;
            if (tk) break;
        end
        RREADY <= 1'b0;
        @(posedge REF_CLK);
        chk(32'(i < 50), 32'h1);
        if (i == 50) finish_test();
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] m,
               input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(d & m, e);
    endtask
    task poll(input logic [31:0] m, input logic [31:0] e);
        int j;
        logic [31:0] d;
        logic [1:0] r;
        for (j = 0; j < 60; j++)
        begin
            axr(`IDX_VALID_STATUS_REGS * 4, d, r);
            if ((d & m) === e) break;
            repeat (20) @(posedge REF_CLK);
        end
        chk(d & m, e);
        if (j == 60) finish_test();
    endtask
    task selchk(input logic [1:0] s, input logic v);
        repeat (4) @(negedge REF_CLK);
        chk(32'({SEL_VALID, SEL_REF}), 32'({v, s}));
    endtask
    initial
    begin
        repeat (20) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        rdchk(`IDX_ENABLE * 4, 32'hFFFFFFFF, `RST_ENABLE);
        rdchk(`IDX_PRIO_A * 4, 32'hFFFFFFFF, `RST_PRIO_A);
        rdchk(`IDX_PRIO_B * 4, 32'hFFFFFFFF, `RST_PRIO_B);
        rdchk(`IDX_VALCTRL * 4, 32'hFFFFFFFF, `RST_VALCTRL);
        rdchk(`IDX_PCTCFG * 4, 32'hFFFFFFFF, `RST_PCTCFG);
        rdchk(`IDX_ACTCFG * 4, 32'hFFFFFFFF, `RST_ACTCFG);
        rdchk(8'h40, 32'hFFFFFFFF, 32'h0);
        axw(`IDX_STATUS * 4, 32'hFFFFFFFF, `RESP_SLVERR);
        axw(`IDX_ACTCFG * 4, 32'h0528_0064, `RESP_OKAY);
        for (k = 0; k < 3; k++)
            axw(8'((`IDX_NOM1 + k) * 4), 32'h19, `RESP_OKAY);
        axw(`IDX_TIMECFG * 4, 32'h2, `RESP_OKAY);
        axw(`IDX_GPIOCFG * 4, 32'h1, `RESP_OKAY);
        axw(`IDX_MONCFG * 4, 32'h0003_030B, `RESP_OKAY);
        poll(32'h7, 32'h7);
        selchk(2'h0, 1'b1);
        axw(`IDX_VALID_STATUS_REGS * 4, 32'h0007_0700, `RESP_OKAY);
        rdchk(`IDX_VALID_STATUS_REGS * 4, 32'h0000_0700, 32'h0);
        axw(`IDX_INCFG * 4, 32'h4, `RESP_OKAY);
        n = 0;
        for (k = 0; k < 160; k++)
        begin
            @(negedge REF_CLK);
            if (DIV_EDGE[0] === 1'b1) n++;
        end
        chk(32'(n >= 9 && n <= 11), 32'h1);
        axw(`IDX_INCFG * 4, 32'h0, `RESP_OKAY);
        half[2] <= 4'h1;
        poll(32'h7, 32'h3);
        rdchk(`IDX_VALID_STATUS_REGS * 4, 32'h400, 32'h400);
        rdchk(`IDX_STATUS * 4, 32'h000B_0000, 32'h0);
        axw(`IDX_VALCTRL * 4, 32'h6, `RESP_OKAY);
        selchk(2'h1, 1'b1);
        half[1] <= 4'h0;
        poll(32'h7, 32'h1);
        selchk(2'h0, 1'b0);
        axw(`IDX_VALCTRL * 4, 32'h7, `RESP_OKAY);
        half <= {4'h2, 4'h2, 4'h2};
        poll(32'h7, 32'h7);
        axw(`IDX_PRIO_A * 4, 32'h10, `RESP_OKAY);
        selchk(2'h1, 1'b1);
        axw(`IDX_PRIO_A * 4, 32'h21, `RESP_OKAY);
        GPIO_PIN_IN[0] <= 1'b0;
        poll(32'h1, 32'h0);
        rdchk(`IDX_STATUS * 4, 32'h5, 32'h4);
        selchk(2'h1, 1'b1);
        axw(`IDX_SELCTRL * 4, 32'h2, `RESP_OKAY);
        GPIO_PIN_IN[0] <= 1'b1;
        poll(32'h1, 32'h1);
        selchk(2'h0, 1'b1);
        half[0] <= 4'h0;
        poll(32'h1, 32'h0);
        axw(`IDX_MONCFG * 4, 32'h0003_0300, `RESP_OKAY);
        poll(32'h1, 32'h1);
        axw(`IDX_ENABLE * 4, 32'h3, `RESP_OKAY);
        poll(32'h4, 32'h0);
        axw(`IDX_GPIOCFG * 4, 32'h0000_0501, `RESP_OKAY);
        selchk(2'h0, 1'b1);
        chk(32'({THIRD_PIN_OE, THIRD_PIN_OUT}), 32'h3);
        finish_test();
    end
endmodule // tb
